//--- pic_top.sv
// Interrupt controller: twelve request sources, three flag registers, masks,
// global enable and a level interrupt toward the CPU, reached over AHB-Lite.
// Assumes all request lines and the halt indication are on clk.
`timescale 1ns/100ps
`include "pic_defs.svh"

//Contract
// RL1 - Twelve sources, eleven of them maskable: four port, seven internal.
// RL2 - Tick taps fast/mid/slow; counter zero and match.
// RL3 - Serial-empty and memory write-done request lines.
// RL4 - Interrupt needs a set flag and enable.
// RL5 - Flags set on rising edge while masked in.
// RL6 - Edges while masked out are discarded forever.
// RL7 - Global enable never blocks flag setting.
// RL8 - Reset clears all masks and global enable.
// RL9 - Reading a flag register clears only it.
// RL10 - Writing one clears that flag only.
// RL11 - Requests during service raise fresh interrupt.
// RL12 - Entering halt forces global enable to one.
// RL13 - Port flags: bit n is input n.
// RL14 - Port mask bit n gates input n.
// RL15 - Timebase register: slow3 mid2 fast1 memory0.
// RL16 - Counter register: supply2 zero1 match0, bit3 unused.
// RL17 - Memory write-done maskable, masked after reset.
// RL18 - Global enable is system control bit three.
// RL19 - Serial empty unmasked; drives branch test bit.
// RL20 - Interrupt is a level while condition holds.
// RL21 - New edge beats a simultaneous clear.
module pic_top
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  port_input_req,
  input  wire logic        fast_tick_req,
  input  wire logic        mid_tick_req,
  input  wire logic        slow_tick_req,
  input  wire logic        count_zero_event,
  input  wire logic        count_match_event,
  input  wire logic        serial_buffer_empty_request,
  input  wire logic        supply_check_done_req,
  input  wire logic        nvm_write_done_request,
  input  wire logic        cpu_halt_entry,
  output logic             cpu_irq,
  output logic             branch_test_bit
);

  pic_pkg::pic_req_t    req;         // Source lines gathered by register.
  pic_pkg::pic_aphase_t ap_q;        // Captured address phase.
  logic [3:0]           port_flags_q;  // Port input flags.
  logic [3:0]           tb_flags_q;    // Tick and memory write-done flags.
  logic [3:0]           cnt_flags_q;   // Counter and supply level flags.
  logic [3:0]           port_irq_masks_q;  // Port input masks.
  logic [3:0]           tb_masks_q;        // Tick and memory masks.
  logic [3:0]           cnt_masks_q;       // Counter and supply masks.
  logic                 global_irq_enable_q;  // CPU interrupt gate.
  logic                 serial_empty_q;       // Sticky unmaskable serial request.
  logic                 serial_prev_q;        // Previous serial request level.
  logic                 ap_take;   // A valid address phase this cycle.
  logic                 rd_now;    // Address phase of a read.
  logic                 wr_now;    // Data phase of a write.
  logic [3:0]           wdat;      // Low nibble of the write data.
  logic [3:0]           clr_port, clr_tb, clr_cnt;  // Write-one clear vectors.
  logic                 rd_port, rd_tb, rd_cnt;     // Clearing reads.
  logic [3:0]           rd_nib;    // Nibble returned for a read.
  logic                 any_flag;  // At least one stored request.

  // Gather the sources; the flag register layout lives in this ordering.
  always_comb
  begin
    req = '0;
    req.port = port_input_req;  // [RL13] [RL1]
    req.timebase_nvm[`PIC_SLOW_BIT] = slow_tick_req;  // [RL15] [RL2]
    req.timebase_nvm[`PIC_MID_BIT]  = mid_tick_req;  // [RL15] [RL2]
    req.timebase_nvm[`PIC_FAST_BIT] = fast_tick_req;  // [RL15] [RL2]
    req.timebase_nvm[`PIC_NVM_BIT]  = nvm_write_done_request;  // [RL3] [RL17]
    req.cnt_level[`PIC_SUPPLY_BIT] = supply_check_done_req;  // [RL16]
    req.cnt_level[`PIC_ZERO_BIT]   = count_zero_event;  // [RL16] [RL2]
    req.cnt_level[`PIC_MATCH_BIT]  = count_match_event;  // [RL16] [RL2]
    req.serial_empty = serial_buffer_empty_request;  // [RL3]
  end

  // The slave never stalls and never errors.
  assign ap_take = hsel && hready && (htrans == `PIC_HTRANS_NONSEQ);

  // Capture the address phase so the data phase can decode it.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      ap_q <= '0;
    else if (hready)
    begin
      ap_q.valid <= ap_take;
      ap_q.write <= hwrite;
      ap_q.addr  <= haddr[7:0];
    end
  end

  assign rd_now = ap_take && !hwrite;
  assign wr_now = ap_q.valid && ap_q.write;
  assign wdat   = hwdata[3:0];

  // Reads clear in the cycle they are accepted, so the returned data is pre-clear.
  assign rd_port = rd_now && (haddr[7:0] == `PIC_OFF_PORT_FLAGS);  // [RL9]
  assign rd_tb   = rd_now && (haddr[7:0] == `PIC_OFF_TB_FLAGS);  // [RL9]
  assign rd_cnt  = rd_now && (haddr[7:0] == `PIC_OFF_CNT_FLAGS);  // [RL9]

  // Write-one-to-clear vectors per flag register.
  always_comb
  begin
    clr_port = `PIC_NIB_RESET;
    clr_tb   = `PIC_NIB_RESET;
    clr_cnt  = `PIC_NIB_RESET;
    if (wr_now && ap_q.addr == `PIC_OFF_PORT_FLAGS)
      clr_port = wdat;  // [RL10]
    if (wr_now && ap_q.addr == `PIC_OFF_TB_FLAGS)
      clr_tb = wdat;  // [RL10]
    if (wr_now && ap_q.addr == `PIC_OFF_CNT_FLAGS)
      clr_cnt = wdat & `PIC_CNT_USED;  // [RL10]
  end

  // Port input flags.
  pic_flag_nibble u_port
  (
    .clk      (clk),
    .resetn   (resetn),
    .req      (req.port),
    .mask     (port_irq_masks_q),
    .rd_clear (rd_port),
    .wr_clear (clr_port),
    .flags_q  (port_flags_q)
  );

  // Tick and memory write-done flags.
  pic_flag_nibble u_tb
  (
    .clk      (clk),
    .resetn   (resetn),
    .req      (req.timebase_nvm),
    .mask     (tb_masks_q),
    .rd_clear (rd_tb),
    .wr_clear (clr_tb),
    .flags_q  (tb_flags_q)
  );

  // Counter and supply flags; bit 3 has no source and stays zero.
  pic_flag_nibble u_cnt
  (
    .clk      (clk),
    .resetn   (resetn),
    .req      ({1'b0, req.cnt_level}),
    .mask     (cnt_masks_q & `PIC_CNT_USED),
    .rd_clear (rd_cnt),
    .wr_clear (clr_cnt),
    .flags_q  (cnt_flags_q)
  );

  // Mask registers, all zero after reset so no maskable request is stored.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      port_irq_masks_q <= `PIC_NIB_RESET;  // [RL8] [RL14]
      tb_masks_q       <= `PIC_NIB_RESET;  // [RL8] [RL17]
      cnt_masks_q      <= `PIC_NIB_RESET;  // [RL8]
    end
    else if (wr_now)
    begin
      if (ap_q.addr == `PIC_OFF_PORT_MASKS)
        port_irq_masks_q <= wdat;  // [RL14]
      if (ap_q.addr == `PIC_OFF_TB_MASKS)
        tb_masks_q <= wdat;
      if (ap_q.addr == `PIC_OFF_CNT_MASKS)
        cnt_masks_q <= wdat & `PIC_CNT_USED;
    end
  end

  // Global enable: halt entry forces it on and wins over a software write.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      global_irq_enable_q <= 1'b0;  // [RL8]
    else if (cpu_halt_entry)
      global_irq_enable_q <= 1'b1;  // [RL12]
    else if (wr_now && ap_q.addr == `PIC_OFF_SYSCTL1)
      global_irq_enable_q <= hwdata[`PIC_GIE_BIT];  // [RL18]
  end

  // Serial empty has no mask; it is a sticky request cleared by write-one
  // to the status word. A new edge wins over the clear.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      serial_prev_q  <= 1'b0;
      serial_empty_q <= 1'b0;
    end
    else
    begin
      serial_prev_q <= req.serial_empty;
      if (req.serial_empty && !serial_prev_q)
        serial_empty_q <= 1'b1;  // [RL19] [RL21]
      else if (wr_now && ap_q.addr == `PIC_OFF_STATUS && wdat[0])
        serial_empty_q <= 1'b0;
    end
  end

  assign any_flag = (|port_flags_q) || (|tb_flags_q) || (|cnt_flags_q) || serial_empty_q;

  // Level interrupt, registered; falls as soon as the flags are gone.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      cpu_irq <= 1'b0;
    else
      cpu_irq <= any_flag && global_irq_enable_q;  // [RL4] [RL20] [RL11]
  end

  // The branch test bit mirrors the serial request for conditional jumps.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      branch_test_bit <= 1'b0;
    else
      branch_test_bit <= serial_empty_q;  // [RL19]
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb
  begin
    unique case (haddr[7:0])
      `PIC_OFF_PORT_FLAGS: rd_nib = port_flags_q;
      `PIC_OFF_TB_FLAGS:   rd_nib = tb_flags_q;
      `PIC_OFF_CNT_FLAGS:  rd_nib = cnt_flags_q;
      `PIC_OFF_PORT_MASKS: rd_nib = port_irq_masks_q;
      `PIC_OFF_TB_MASKS:   rd_nib = tb_masks_q;
      `PIC_OFF_CNT_MASKS:  rd_nib = cnt_masks_q;
      `PIC_OFF_SYSCTL1:    rd_nib = {global_irq_enable_q, 3'h0};
      `PIC_OFF_STATUS:     rd_nib = {3'h0, serial_empty_q};
      default:             rd_nib = `PIC_NIB_RESET;
    endcase
  end

  // Read data is registered at the address phase and stands in the data phase.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      hrdata <= `PIC_WORD_ZERO;
    else if (rd_now)
      hrdata <= {28'h0000000, rd_nib};
    else
      hrdata <= `PIC_WORD_ZERO;
  end

  // Zero wait states and OKAY always; kept in flops so outputs are registered.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  AST_IRQ_NEEDS_GIE: assert property (@(posedge clk) disable iff (!resetn)
    !global_irq_enable_q |=> !cpu_irq)  // [RL4]
    else $error("Interrupt raised with global enable off.");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!resetn)
    (any_flag && global_irq_enable_q) |=> cpu_irq)  // [RL20]
    else $error("Interrupt missing while a flag and enable are set.");
  AST_HALT_SETS_GIE: assert property (@(posedge clk) disable iff (!resetn)
    cpu_halt_entry |=> global_irq_enable_q)  // [RL12]
    else $error("Halt entry did not set global enable.");
  AST_RESET_CLEARS: assert property (@(posedge clk)
    !resetn |=> (port_irq_masks_q == 4'h0 && tb_masks_q == 4'h0 && !global_irq_enable_q))  // [RL8]
    else $error("Reset left a mask or enable set.");
  AST_READ_CLEARS: assert property (@(posedge clk) disable iff (!resetn)
    (rd_port && !(|(port_input_req & port_irq_masks_q))) |=> port_flags_q == 4'h0)  // [RL9]
    else $error("Read did not clear the port flags.");
  AST_OTHER_KEPT: assert property (@(posedge clk) disable iff (!resetn)
    (rd_port && !wr_now && tb_flags_q[`PIC_SLOW_BIT]) |=> tb_flags_q[`PIC_SLOW_BIT])  // [RL9]
    else $error("Reading one register cleared another.");
  AST_GIE_NO_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
    (!global_irq_enable_q && tb_masks_q[`PIC_SLOW_BIT] && $rose(slow_tick_req))
    |=> tb_flags_q[`PIC_SLOW_BIT])  // [RL7]
    else $error("Flag not stored while global enable was off.");
  AST_UNUSED_BIT: assert property (@(posedge clk) disable iff (!resetn)
    !cnt_flags_q[3])  // [RL16]
    else $error("Unused counter flag bit became set.");
  AST_SERIAL_UNMASKED: assert property (@(posedge clk) disable iff (!resetn)
    $rose(serial_buffer_empty_request) |=> ##1 branch_test_bit)  // [RL19]
    else $error("Serial empty request did not reach the test bit.");
  AST_W1C_KEEPS_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    (wr_now && ap_q.addr == `PIC_OFF_PORT_FLAGS && !wdat[1] && port_flags_q[1] && !rd_port)
    |=> port_flags_q[1])  // [RL10]
    else $error("Writing zero cleared a flag.");

endmodule

//--- pic_defs.svh
// Register offsets, field positions and reset values of the interrupt controller.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

`define PIC_OFF_PORT_FLAGS   8'h00
`define PIC_OFF_TB_FLAGS     8'h04
`define PIC_OFF_CNT_FLAGS    8'h08
`define PIC_OFF_PORT_MASKS   8'h0C
`define PIC_OFF_TB_MASKS     8'h10
`define PIC_OFF_CNT_MASKS    8'h14
`define PIC_OFF_SYSCTL1      8'h18
`define PIC_OFF_STATUS       8'h1C

`define PIC_GIE_BIT          3
`define PIC_NVM_BIT          0
`define PIC_FAST_BIT         1
`define PIC_MID_BIT          2
`define PIC_SLOW_BIT         3
`define PIC_MATCH_BIT        0
`define PIC_ZERO_BIT         1
`define PIC_SUPPLY_BIT       2
`define PIC_CNT_USED         4'h7
`define PIC_NIB_RESET        4'h0
`define PIC_HTRANS_NONSEQ    2'h2
`define PIC_HSIZE_WORD       3'h2
`define PIC_WORD_ZERO        32'h0000_0000

`endif

//--- pic_pkg.sv
// Types shared by the interrupt controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package pic_pkg;

  // Raw request lines of the twelve sources, grouped as the flag registers are.
  typedef struct packed {
    logic [3:0] port;
    logic [3:0] timebase_nvm;
    logic [2:0] cnt_level;
    logic       serial_empty;
  } pic_req_t;

  // Registered address phase of one AHB-Lite transfer.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } pic_aphase_t;

endpackage

//--- pic_flag_nibble.sv
// One four-bit request flag register with edge capture, masking and clearing.
// Assumes the request lines come from logic on the same clock.
`timescale 1ns/100ps
`include "pic_defs.svh"

module pic_flag_nibble
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] req,
  input  wire logic [3:0] mask,
  input  wire logic       rd_clear,
  input  wire logic [3:0] wr_clear,
  output logic      [3:0] flags_q
);

  logic [3:0] req_q;  // Request levels one cycle ago, for rising-edge detection.
  logic [3:0] set_d;  // Rising edges that the mask lets through.

  // Remember the previous request levels.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      req_q <= `PIC_NIB_RESET;
    else
      req_q <= req;
  end

  // An edge counts only while the mask is one; later unmasking does not revive it.
  assign set_d = req & ~req_q & mask;  // [RL5] [RL6] [RL7]

  // Clears act first and new edges override them, so no request is lost.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      flags_q <= `PIC_NIB_RESET;
    else if (rd_clear)
      flags_q <= set_d;  // [RL9] [RL21]
    else
      flags_q <= (flags_q & ~wr_clear) | set_d;  // [RL10] [RL21] [RL11]
  end

  AST_EDGE_SETS: assert property (@(posedge clk) disable iff (!resetn)
    (req[0] && !req_q[0] && mask[0]) |=> flags_q[0])  // [RL5]
    else $error("Masked-in edge did not set its flag.");
  AST_MASKED_DROPPED: assert property (@(posedge clk) disable iff (!resetn)
    (!flags_q[0] && !(req[0] && !req_q[0] && mask[0])) |=> !flags_q[0])  // [RL6]
    else $error("Flag set without an admitted edge.");

endmodule

//--- pic_cpu_model.sv
// Behavioural model of the 4-bit CPU core that sits on the far side of the controller.
// Assumes the controller's level interrupt and a halt request from the bench, both on clk.
`timescale 1ns/100ps

module pic_cpu_model
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       cpu_irq,
  input  wire logic       halt_req,
  output logic            cpu_halt_entry,
  output logic      [7:0] irq_entries_q
);
  logic irq_seen_q; // Last sampled interrupt level, used to spot a new service entry.

  // Halt entry is a one-cycle pulse one edge after the bench asks for it.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      cpu_halt_entry <= 1'b0;
    else
      cpu_halt_entry <= halt_req;
  end

  // The single service routine is entered once for each rise of the interrupt level.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      irq_seen_q    <= 1'b0;
      irq_entries_q <= 8'h00;
    end
    else
    begin
      irq_seen_q <= cpu_irq;
      if (cpu_irq && !irq_seen_q)
        irq_entries_q <= irq_entries_q + 8'h01;
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the interrupt controller, driven over AHB-Lite.
// Assumes hready is fed back from hreadyout and the CPU model drives the halt pulse.
`timescale 1ns/100ps

module tb;
  logic        clk;         // System clock, 50 MHz.
  logic        resetn;      // Synchronous reset, active low.
  logic        hsel;        // Bus select.
  logic [31:0] haddr;       // Bus address.
  logic [1:0]  htrans;      // Transfer type.
  logic        hwrite;      // Write strobe.
  logic [2:0]  hsize;       // Transfer size.
  logic [31:0] hwdata;      // Write data.
  logic [31:0] hrdata;      // Read data.
  logic        hreadyout;   // Slave ready, fed back as hready.
  logic        hresp;       // Response, always OKAY.
  logic [11:0] src;         // Source lines laid out as the three flag registers.
  logic        halt_req;    // Asks the CPU model for a halt entry.
  logic        halt_entry;  // Halt pulse from the CPU model.
  logic        cpu_irq;     // Interrupt toward the CPU.
  logic        branch_bit;  // Serial empty test bit.
  logic [7:0]  entries;     // Service entries seen by the CPU model.
  int          n_fail;      // Mismatches.
  int          check_count; // Comparisons.
  int          cyc = 0;     // Cycle count for the timeout.
  logic [7:0]  entries_wire; // Model output, copied for readability.

  pic_top dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_input_req(src[3:0]),
    .nvm_write_done_request(src[4]), .fast_tick_req(src[5]), .mid_tick_req(src[6]),
    .slow_tick_req(src[7]), .count_match_event(src[8]), .count_zero_event(src[9]),
    .supply_check_done_req(src[10]), .serial_buffer_empty_request(src[11]),
    .cpu_halt_entry(halt_entry), .cpu_irq(cpu_irq), .branch_test_bit(branch_bit));

  pic_cpu_model cpu (.clk(clk), .resetn(resetn), .cpu_irq(cpu_irq), .halt_req(halt_req),
    .cpu_halt_entry(halt_entry), .irq_entries_q(entries_wire));
  assign entries = entries_wire;

  always #10 clk = ~clk;

  // A hang counts as a mismatch and ends the run through the common report.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One comparison; four-state equality so an unknown never matches.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask

  // One single AHB-Lite word transfer; each phase is held until hready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    logic [31:0] x;
    bus(1'b1, a, {28'h0000000, d}, x);
  endtask

  task automatic rd(input logic [7:0] a, input logic [3:0] e, input string nm);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(nm, {28'h0000000, e}, x);
  endtask

  // Raise the chosen source lines for one cycle, then let the flags settle.
  task automatic pulse(input logic [11:0] v);
    @(posedge clk);
    src <= v;
    @(posedge clk);
    src <= 12'h000;
    repeat (2) @(posedge clk);
  endtask

  // The interrupt is registered, so give it a full cycle before looking.
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    chk("cpu_irq", {31'h00000000, e}, {31'h00000000, cpu_irq});
  endtask

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    src = 12'h000;
    halt_req = 1'b0;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h0C, 4'h0, "port_masks");
    rd(8'h10, 4'h0, "timebase_masks");
    rd(8'h14, 4'h0, "counter_masks");
    rd(8'h18, 4'h0, "system_control_one");
    // Edges while masked out must never show up later.
    pulse(12'h0FF);
    wr(8'h0C, 4'hF);
    wr(8'h10, 4'hF);
    wr(8'h14, 4'h7);
    rd(8'h00, 4'h0, "port_flags_masked");
    rd(8'h04, 4'h0, "timebase_flags_masked");
    // Bit placement of every maskable source, with the global enable still off.
    pulse(12'h59F);
    irq_is(1'b0);
    rd(8'h00, 4'hF, "port_flags");
    rd(8'h00, 4'h0, "port_flags_after_read");
    rd(8'h04, 4'h9, "timebase_flags");
    rd(8'h08, 4'h5, "counter_flags");
    pulse(12'h260);
    rd(8'h04, 4'h6, "timebase_flags_b");
    rd(8'h08, 4'h2, "counter_flags_b");
    // Writing ones clears only those flags.
    pulse(12'h00F);
    wr(8'h00, 4'h5);
    rd(8'h00, 4'hA, "port_flags_w1c");
    // Interrupt level follows flags and enable; pending requests keep it up.
    pulse(12'h001);
    irq_is(1'b0);
    wr(8'h18, 4'h8);
    irq_is(1'b1);
    pulse(12'h010);
    rd(8'h00, 4'h1, "port_flags_service");
    irq_is(1'b1);
    rd(8'h04, 4'h1, "timebase_flags_service");
    irq_is(1'b0);
    chk("service_entries", 32'h00000001, {24'h000000, entries});
    // An unmapped place reads as zero and ignores writes.
    wr(8'h20, 4'hF);
    rd(8'h20, 4'h0, "unmapped");
    // The serial empty request has no mask and sets the test bit.
    wr(8'h0C, 4'h0);
    pulse(12'h800);
    chk("branch_test_bit", 32'h00000001, {31'h00000000, branch_bit});
    irq_is(1'b1);
    wr(8'h1C, 4'h1);
    irq_is(1'b0);
    // Halt entry forces the global enable back on.
    wr(8'h18, 4'h0);
    rd(8'h18, 4'h0, "enable_off");
    @(posedge clk);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h18, 4'h8, "enable_after_halt");
    // A reset in mid-run must clear the masks and the enable once more.
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h10, 4'h0, "timebase_masks_after_reset");
    rd(8'h18, 4'h0, "enable_after_reset");
    chk("hresp", 32'h00000000, {31'h00000000, hresp});
    end_sim();
  end
endmodule
